// file: core/eaf_regs.svh
`ifndef EAF_REGS_SVH
`define EAF_REGS_SVH
// Register byte offsets (low address byte)
`define EAF_CTRL_OFS 8'h00
`define EAF_STAT_OFS 8'h04
`define EAF_EA_OFS 8'h08
`define EAF_PSEL_OFS 8'h0C
`define EAF_PDAT_OFS 8'h10
`define EAF_CTRL_RST 1'h0
// Decode word layout
`define EAF_W_BITS 13
`define EAF_W_ENT_LSB 9
`define EAF_W_IND 8
`define EAF_W_LONG 7
`define EAF_W_POST 6
`define EAF_W_PRE 5
`define EAF_W_ITA 4
`define EAF_W_TRAP 3
`define EAF_W_DA 2
`define EAF_W_DB 1
`define EAF_W_GEN 0
`define EAF_PROM_N 3
`define EAF_PROM_D 16
`endif

// file: core/eaf_pkg.sv
`include "eaf_regs.svh"
package eaf_pkg;
   typedef enum logic [1:0] {EAF_MODE_S, EAF_MODE_R, EAF_MODE_V, EAF_MODE_I} eaf_mode_t;
   typedef enum logic [2:0] {
      EAF_F_NONE, EAF_F_DIRECT, EAF_F_INDEXED, EAF_F_IND, EAF_F_PRE, EAF_F_POST
   } eaf_form_t;
   typedef enum logic {EAF_ST_RUN, EAF_ST_CHAIN} eaf_st_t;
   typedef logic [`EAF_W_BITS-1:0] eaf_word_t;
   typedef struct packed {
      eaf_word_t [`EAF_PROM_N-1:0][`EAF_PROM_D-1:0] prom;
      logic en;
      logic [5:0] psel;
      logic a_wr;
      logic [7:0] a_addr;
      logic [31:0] rdata;
      logic s4_v;
      eaf_word_t s4_word;
      eaf_form_t s4_form;
      logic [31:0] s4_base;
      logic [31:0] s4_off;
      logic [15:0] s4_idx;
      logic s5_v;
      eaf_form_t s5_form;
      logic [31:0] s5_sum;
      logic [15:0] s5_idx;
      logic [3:0] s5_ent;
      eaf_st_t st;
      logic [31:0] ch_addr;
      logic ch_post;
      logic [15:0] ch_idx;
      logic [3:0] ch_ent;
      logic [31:0] ea;
      logic ea_v;
   } eaf_state_t;
endpackage

// file: core/eaf_unit.sv
// Behaviour
// - Pick direct, indexed, indirect or indirect-indexed from instruction fields.
// - Address math in stages five and six; result registered end of six.
// - Direct: base register plus displacement.
// - Indexed: base plus index plus displacement.
// - Short indirection: displacement addresses procedure segment; fetched word is address.
// - Follow fetched indirect addresses until one holds no further indirection.
// - Long indirection: displacement points at word holding full effective address.
// - Preindexed: index, base, displacement summed, then chain resolved.
// - Postindexed: base plus displacement, chain resolved, then index added.
// - Native mode: 16-bit displacement; unnamed base uses procedure base, low half zero.
// - Virtual short with sector set: signed 9-bit displacement plus program counter.
// - Virtual short sector clear: field picks stack or link base plus displacement.
// - Relative long: opcode bits 15,16 pick stack base or zero.
// - Relative short: sector set adds to program counter, clear adds to zero.
// - Three decode PROMs addressed by microsequencer-supplied encoded address.
// - Four decode bits go to microsequencer as sixteen dispatch points.
// - Nine decode flags steer the addressing.
// - Two decode address bits also drive ring weakening.
// - PROM outputs share one bus; exactly one PROM enabled by mode.
// - PROMs read in stage four; decode registered at its end.
// - Microcode help stalls front end until microcode finishes.
// - Native type field: 3 indirect/post, 2 indirect/pre, 1 direct/indexed, 0 none.
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "eaf_regs.svh"
module eaf_unit (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   // Stage four instruction side
   input wire logic valid_i,
   input wire eaf_pkg::eaf_mode_t mode_i,
   input wire logic [3:0] prom_addr_i,
   input wire logic [1:0] address_type_field_i,
   input wire logic [1:0] cb_bits_i,
   input wire logic sector_bit_i,
   input wire logic [15:0] disp_i,
   input wire logic base_named_i,
   input wire logic index_named_i,
   input wire logic [31:0] selected_base_reg_i,
   input wire logic [31:0] procedure_base_i,
   input wire logic [31:0] stack_base_i,
   input wire logic [31:0] link_base_i,
   input wire logic [15:0] program_counter_word_i,
   input wire logic [15:0] index_reg_i,
   output logic stall_o,
   // Decode flags
   output logic [1:0] ring_weak_o,
   output logic address_trap_enable_o,
   output logic reg_or_immediate_type_flag_o,
   output logic generic_form_flag_o,
   // Microsequencer help and indirect reads
   output logic ucode_req_o,
   output logic [3:0] ucode_entry_o,
   output logic ind_req_o,
   output logic [31:0] ind_addr_o,
   input wire logic ind_ack_i,
   input wire logic [31:0] ind_data_i,
   input wire logic ind_more_i,
   // Cache / translation_buffer address
   output logic [31:0] ea_o,
   output logic ea_v_o
);
   import eaf_pkg::*;

   eaf_state_t state_ff;
   eaf_state_t nxt_state;
   logic [1:0] psel_mode;
   eaf_word_t [`EAF_PROM_N-1:0] prom_bus;
   eaf_word_t prom_word;
   logic take;

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic is_ind(input eaf_form_t f);
      is_ind = (f == EAF_F_IND) || (f == EAF_F_PRE) || (f == EAF_F_POST);
   endfunction

   function automatic eaf_form_t form_of(
      input eaf_mode_t m, input logic [1:0] tf, input eaf_word_t w, input logic ix);
      eaf_form_t f;
      f = EAF_F_NONE;
      if (m == EAF_MODE_I) begin
         unique case (tf)
            2'h3: f = ix ? EAF_F_POST : EAF_F_IND;
            2'h2: f = ix ? EAF_F_PRE : EAF_F_IND;
            2'h1: f = ix ? EAF_F_INDEXED : EAF_F_DIRECT;
            2'h0: f = EAF_F_NONE;
         endcase
      end else if (w[`EAF_W_IND]) begin
         if (w[`EAF_W_POST]) begin
            f = EAF_F_POST;
         end else if (w[`EAF_W_PRE]) begin
            f = EAF_F_PRE;
         end else begin
            f = EAF_F_IND;
         end
      end else if (w[`EAF_W_PRE] | w[`EAF_W_POST]) begin
         f = EAF_F_INDEXED;
      end else begin
         f = EAF_F_DIRECT;
      end
      return f;
   endfunction

   function automatic logic [31:0] reg_read(input eaf_state_t s, input logic [7:0] a);
      logic [31:0] d;
      d = 32'h0000_0000;
      unique case (a)
         `EAF_CTRL_OFS: d = {31'h0000_0000, s.en};
         `EAF_STAT_OFS: d = {27'h000_0000, s.ch_ent, s.st == EAF_ST_CHAIN};
         `EAF_EA_OFS: d = s.ea;
         `EAF_PSEL_OFS: d = {26'h000_0000, s.psel};
         `EAF_PDAT_OFS: begin
            if (s.psel[5:4] != 2'h3) begin
               d = {19'h0_0000, s.prom[s.psel[5:4]][s.psel[3:0]]};
            end
         end
         default: d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // One PROM drives the shared bus; the others float, modelled as zero
   assign psel_mode = (mode_i == EAF_MODE_I) ? 2'h2 : (mode_i == EAF_MODE_V) ? 2'h1 : 2'h0;
   generate
      for (genvar g = 0; g < `EAF_PROM_N; g++) begin : g_prom
         assign prom_bus[g] = (psel_mode == 2'(g)) ?
            state_ff.prom[g][prom_addr_i] : '0;
      end
   endgenerate
   assign prom_word = prom_bus[0] | prom_bus[1] | prom_bus[2];

   // Help needed anywhere in flight holds the front end
   assign stall_o = (state_ff.st == EAF_ST_CHAIN) |
      (state_ff.s4_v & is_ind(state_ff.s4_form)) |
      (state_ff.s5_v & is_ind(state_ff.s5_form));
   assign take = valid_i & state_ff.en & ~stall_o;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      eaf_word_t w;
      logic [31:0] sx9;
      logic [31:0] sx16;
      logic [31:0] pb_seg;
      w = prom_word;
      sx9 = {{23{disp_i[8]}}, disp_i[8:0]};
      sx16 = {{16{disp_i[15]}}, disp_i};
      pb_seg = {procedure_base_i[31:16], 16'h0000};
      nxt_state = state_ff;
      nxt_state.ea_v = 1'b0;

      // Bus address phase; data phase write uses the captured address
      nxt_state.a_wr = hready_i & hsel_i & htrans_i[1] & hwrite_i;
      if (hready_i) begin
         nxt_state.a_addr = haddr_i[7:0];
      end
      if (hready_i & hsel_i & htrans_i[1] & ~hwrite_i) begin
         nxt_state.rdata = reg_read(state_ff, haddr_i[7:0]);
      end
      if (state_ff.a_wr) begin
         unique case (state_ff.a_addr)
            `EAF_CTRL_OFS: nxt_state.en = hwdata_i[0];
            `EAF_PSEL_OFS: nxt_state.psel = hwdata_i[5:0];
            `EAF_PDAT_OFS: begin
               if (state_ff.psel[5:4] != 2'h3) begin
                  nxt_state.prom[state_ff.psel[5:4]][state_ff.psel[3:0]] =
                     hwdata_i[`EAF_W_BITS-1:0];
               end
            end
            default: ;
         endcase
      end

      // Stage four: decode read and base selection
      nxt_state.s4_v = take;
      if (take) begin
         nxt_state.s4_word = w;
         nxt_state.s4_form = form_of(mode_i, address_type_field_i, w, index_named_i);
         nxt_state.s4_idx = index_reg_i;
         nxt_state.s4_off = sx16;
         unique case (mode_i)
            EAF_MODE_I: begin
               // Unnamed base falls back to procedure base with zero low half
               nxt_state.s4_base = base_named_i ? selected_base_reg_i : pb_seg;
            end
            EAF_MODE_V: begin
               if (w[`EAF_W_LONG]) begin
                  nxt_state.s4_base = base_named_i ? selected_base_reg_i : pb_seg;
               end else if (sector_bit_i) begin
                  nxt_state.s4_base = {procedure_base_i[31:16], program_counter_word_i};
                  nxt_state.s4_off = sx9;
               end else begin
                  nxt_state.s4_base = disp_i[8] ? link_base_i : stack_base_i;
                  nxt_state.s4_off = {24'h00_0000, disp_i[7:0]};
               end
            end
            default: begin
               if (w[`EAF_W_LONG]) begin
                  nxt_state.s4_base = (cb_bits_i == 2'h3) ? stack_base_i : pb_seg;
               end else if (sector_bit_i) begin
                  nxt_state.s4_base = {procedure_base_i[31:16], program_counter_word_i};
                  nxt_state.s4_off = sx9;
               end else begin
                  // Zero offset within the procedure segment, also the indirect pointer
                  nxt_state.s4_base = pb_seg;
                  nxt_state.s4_off = {23'h00_0000, disp_i[8:0]};
               end
            end
         endcase
      end

      // Stage five: adder path, index joins here for indexed and preindexed forms only
      nxt_state.s5_v = state_ff.s4_v;
      nxt_state.s5_form = state_ff.s4_form;
      nxt_state.s5_idx = state_ff.s4_idx;
      nxt_state.s5_ent = state_ff.s4_word[`EAF_W_ENT_LSB +: 4];
      nxt_state.s5_sum = state_ff.s4_base + state_ff.s4_off;
      if (state_ff.s4_form == EAF_F_INDEXED || state_ff.s4_form == EAF_F_PRE) begin
         nxt_state.s5_sum = state_ff.s4_base + state_ff.s4_off +
            {16'h0000, state_ff.s4_idx};
      end

      // Stage six: deliver or hand over to the chain walk
      unique case (state_ff.st)
         EAF_ST_RUN: begin
            if (state_ff.s5_v && is_ind(state_ff.s5_form)) begin
               nxt_state.st = EAF_ST_CHAIN;
               nxt_state.ch_addr = state_ff.s5_sum;
               nxt_state.ch_post = (state_ff.s5_form == EAF_F_POST);
               nxt_state.ch_idx = state_ff.s5_idx;
               nxt_state.ch_ent = state_ff.s5_ent;
            end else if (state_ff.s5_v && state_ff.s5_form != EAF_F_NONE) begin
               nxt_state.ea = state_ff.s5_sum;
               nxt_state.ea_v = 1'b1;
            end
         end
         EAF_ST_CHAIN: begin
            if (ind_ack_i) begin
               if (ind_more_i) begin
                  nxt_state.ch_addr = ind_data_i;
               end else begin
                  // Fetched word is the full address; post index added last
                  nxt_state.ea = ind_data_i +
                     (state_ff.ch_post ? {16'h0000, state_ff.ch_idx} : 32'h0000_0000);
                  nxt_state.ea_v = 1'b1;
                  nxt_state.st = EAF_ST_RUN;
               end
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= '0;
         state_ff.en <= `EAF_CTRL_RST;
         state_ff.st <= EAF_ST_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Zero wait state slave; read data is captured in the address phase
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign hrdata_o = state_ff.rdata;

   assign ring_weak_o = {state_ff.s4_word[`EAF_W_DA], state_ff.s4_word[`EAF_W_DB]};
   assign address_trap_enable_o = state_ff.s4_word[`EAF_W_TRAP];
   assign reg_or_immediate_type_flag_o = state_ff.s4_word[`EAF_W_ITA];
   assign generic_form_flag_o = state_ff.s4_word[`EAF_W_GEN];
   assign ucode_req_o = (state_ff.st == EAF_ST_CHAIN);
   assign ucode_entry_o = state_ff.ch_ent;
   assign ind_req_o = (state_ff.st == EAF_ST_CHAIN);
   assign ind_addr_o = state_ff.ch_addr;
   assign ea_o = state_ff.ea;
   assign ea_v_o = state_ff.ea_v;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb_eaf @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_ind_enter;
      state_ff.s5_v && is_ind(state_ff.s5_form) && state_ff.st == EAF_ST_RUN;
   endsequence

   sequence s_chain_last;
      state_ff.st == EAF_ST_CHAIN && ind_ack_i && !ind_more_i;
   endsequence

   chk_direct_sum: assert property (
      state_ff.s4_v && state_ff.s4_form == EAF_F_DIRECT
      |=> state_ff.s5_sum == $past(state_ff.s4_base + state_ff.s4_off))
      else $error("direct sum wrong");

   chk_index_sum: assert property (
      state_ff.s4_v && state_ff.s4_form == EAF_F_INDEXED
      |=> state_ff.s5_sum == $past(state_ff.s4_base + state_ff.s4_off +
                                  {16'h0000, state_ff.s4_idx}))
      else $error("indexed sum wrong");

   chk_direct_latency: assert property (
      take && mode_i == EAF_MODE_I && address_type_field_i == 2'h1
      |=> ##1 !ea_v_o ##1 ea_v_o && ea_o == $past(state_ff.s5_sum))
      else $error("direct address not out at end of stage six");

   chk_decode_reg: assert property (
      take |=> state_ff.s4_word == $past(prom_word) && state_ff.s4_v)
      else $error("decode not registered after stage four");

   chk_pc_rel: assert property (
      take && mode_i == EAF_MODE_V && !prom_word[`EAF_W_LONG] && sector_bit_i
      |=> state_ff.s4_off == $past({{23{disp_i[8]}}, disp_i[8:0]}) &&
          state_ff.s4_base[15:0] == $past(program_counter_word_i))
      else $error("program counter relative form wrong");

   chk_help_stall: assert property (
      s_ind_enter |=> stall_o && ucode_req_o && ucode_entry_o == $past(state_ff.s5_ent))
      else $error("help request without stall");

   chk_chain_follow: assert property (
      state_ff.st == EAF_ST_CHAIN && ind_ack_i && ind_more_i
      |=> ind_req_o && ind_addr_o == $past(ind_data_i))
      else $error("chain not followed");

   chk_chain_done: assert property (
      s_chain_last |=> ea_v_o && !ucode_req_o &&
         ea_o == $past(ind_data_i + (state_ff.ch_post ? {16'h0000, state_ff.ch_idx} : 32'h0))
      ) else $error("chain result wrong");

   chk_no_take_stall: assert property (
      stall_o |=> !state_ff.s4_v)
      else $error("instruction taken while stalled");

endmodule
`default_nettype wire

// file: test/eaf_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module eaf_mem_model (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic req_i,
   input wire logic [31:0] addr_i,
   input wire logic slow_i,
   output logic ack_o,
   output logic [31:0] data_o,
   output logic more_o
);
   logic [1:0] wait_ff;
   ////////////////////////////////////////////////////////////////////////////////
   // Pointers with top nibble A lead on to B, so the bench can build two-level chains
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_ff <= 2'h0;
         ack_o <= 1'b0;
         data_o <= 32'h5A5A_5A5A;
         more_o <= 1'b0;
      end else begin
         ack_o <= 1'b0;
         if (ack_o) begin
            // Bus released: scramble so a late sample cannot look right
            data_o <= ~data_o;
            more_o <= ~more_o;
            wait_ff <= 2'h0;
         end else if (req_i && (wait_ff >= (slow_i ? 2'h3 : 2'h0))) begin
            ack_o <= 1'b1;
            more_o <= (addr_i[31:28] == 4'hA);
            data_o <= (addr_i[31:28] == 4'hA) ? {4'hB, addr_i[27:0]} : addr_i + 32'h1000;
            wait_ff <= 2'h0;
         end else if (req_i) begin
            wait_ff <= wait_ff + 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

// file: test/tb_effective_address_formation.sv
`timescale 1ns/1ps
`default_nettype none
`include "eaf_regs.svh"
module tb_effective_address_formation;
   import eaf_pkg::*;
   logic core_clk_i = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0, valid = 1'b0, sec_b = 1'b0, bnm = 1'b0, xnm = 1'b0;
   logic slow = 1'b0;
   logic [1:0] htrans = 2'h0, tfld = 2'h0, cbb = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [3:0] paddr = 4'h0;
   logic [15:0] disp = 16'h0;
   logic [15:0] pcw = 16'h0400, idx = 16'h0030;
   eaf_mode_t mode = EAF_MODE_S;
   wire logic hrdy, hresp, ucode_req_o, ind_req_o, ind_ack, ind_more, stall_o, ea_v_o;
   wire logic trap_o, ita_o, gen_o;
   wire logic [1:0] ring_weak_o;
   wire logic [3:0] ucode_entry_o;
   wire logic [31:0] hrdata, ind_addr_o, ind_data, ea_o;
   logic [12:0] pw [0:2][0:15] = '{default: 13'h0};
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [31:0] v;

   eaf_unit dut (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata),
      .valid_i(valid), .mode_i(mode), .prom_addr_i(paddr), .address_type_field_i(tfld),
      .cb_bits_i(cbb), .sector_bit_i(sec_b), .disp_i(disp), .base_named_i(bnm),
      .index_named_i(xnm), .selected_base_reg_i(32'hA010_0000),
      .procedure_base_i(32'h0005_1234), .stack_base_i(32'h0002_0000),
      .link_base_i(32'h0007_0000), .program_counter_word_i(pcw),
      .index_reg_i(idx), .stall_o(stall_o), .ring_weak_o(ring_weak_o),
      .address_trap_enable_o(trap_o), .reg_or_immediate_type_flag_o(ita_o),
      .generic_form_flag_o(gen_o), .ucode_req_o(ucode_req_o), .ucode_entry_o(ucode_entry_o),
      .ind_req_o(ind_req_o), .ind_addr_o(ind_addr_o), .ind_ack_i(ind_ack),
      .ind_data_i(ind_data), .ind_more_i(ind_more), .ea_o(ea_o), .ea_v_o(ea_v_o));

   eaf_mem_model mem (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n), .req_i(ind_req_o), .addr_i(ind_addr_o),
      .slow_i(slow), .ack_o(ind_ack), .data_o(ind_data), .more_o(ind_more));

   initial begin
      forever #5 core_clk_i = ~core_clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("mismatches %0d comparisons %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // AHB-Lite single word transfers, called right after a rising edge
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      @(posedge core_clk_i);
      while (hrdy !== 1'b1) @(posedge core_clk_i);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wr ? d : 32'h0;
      @(posedge core_clk_i);
      while (hrdy !== 1'b1) @(posedge core_clk_i);
      q = hrdata;
   endtask

   task automatic load(input logic [1:0] p, input logic [3:0] e, input logic [12:0] w);
      logic [31:0] q;
      pw[p][e] = w;
      ahb(1'b1, `EAF_PSEL_OFS, {26'h0, p, e}, q);
      ahb(1'b1, `EAF_PDAT_OFS, {19'h0, w}, q);
   endtask

   // lat: 2 hardware path, 0 microcode chain, -1 no address expected
   task automatic run(input eaf_mode_t m, input logic [3:0] pa, input logic [1:0] tf,
                      input logic [1:0] cb, input logic sec, input logic bn, input logic xn,
                      input logic [15:0] d, input logic [31:0] ptr, input logic [31:0] exp,
                      input int lat);
      int p;
      int n;
      logic seen;
      logic [12:0] w;
      p = (m == EAF_MODE_I) ? 2 : ((m == EAF_MODE_V) ? 1 : 0);
      w = pw[p][pa];
      mode <= m; paddr <= pa; tfld <= tf; cbb <= cb; sec_b <= sec;
      bnm <= bn; xnm <= xn; disp <= d; valid <= 1'b1;
      @(posedge core_clk_i);
      valid <= 1'b0;
      @(negedge core_clk_i);
      chk("decode", {27'h0, w[2], w[1], w[3], w[4], w[0]},
          {27'h0, ring_weak_o, trap_o, ita_o, gen_o});
      n = 0;
      seen = 1'b0;
      while (ea_v_o !== 1'b1 && n < ((lat < 0) ? 8 : 40)) begin
         if (lat == 0 && n == 0) chk("stall", 32'h1, {31'h0, stall_o});
         if (lat != 0) chk("stall", 32'h0, {31'h0, stall_o});
         if (ind_req_o === 1'b1 && !seen) begin
            chk("ind_addr", ptr, ind_addr_o);
            chk("entry", {28'h0, w[12:9]}, {28'h0, ucode_entry_o});
            seen = 1'b1;
         end
         n++;
         @(negedge core_clk_i);
      end
      chk("ea_valid", (lat < 0) ? 32'h0 : 32'h1, {31'h0, ea_v_o});
      if (lat > 0) chk("latency", lat, n);
      if (lat >= 0) chk("ea", exp, ea_o);
      @(posedge core_clk_i);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge core_clk_i);
      rst_n <= 1'b1;
      @(posedge core_clk_i);
      ahb(1'b0, `EAF_CTRL_OFS, 32'h0, v);
      chk("ctrl_reset", 32'h0, v);
      load(2'h2, 4'h1, 13'h0A0D);
      load(2'h2, 4'h2, 13'h1302);
      load(2'h2, 4'h3, 13'h0012);
      load(2'h0, 4'h1, 13'h0084);
      load(2'h0, 4'h2, 13'h0008);
      load(2'h1, 4'h3, 13'h1E01);
      ahb(1'b1, `EAF_PSEL_OFS, 32'h21, v);
      ahb(1'b0, `EAF_PDAT_OFS, 32'h0, v);
      chk("prom_readback", 32'h0A0D, v);
      ahb(1'b0, 8'h40, 32'h0, v);
      chk("unmapped", 32'h0, v);
      chk("hresp_okay", 32'h0, {31'h0, hresp});
      ahb(1'b1, `EAF_CTRL_OFS, 32'h1, v);
      run(EAF_MODE_I, 4'h1, 2'h1, 2'h0, 1'b0, 1'b1, 1'b0, 16'h0010, 0, 32'hA010_0010, 2);
      run(EAF_MODE_I, 4'h1, 2'h1, 2'h0, 1'b0, 1'b1, 1'b1, 16'h0010, 0, 32'hA010_0040, 2);
      run(EAF_MODE_I, 4'h1, 2'h1, 2'h0, 1'b0, 1'b0, 1'b0, 16'hFFF0, 0, 32'h0004_FFF0, 2);
      run(EAF_MODE_I, 4'h3, 2'h0, 2'h0, 1'b0, 1'b1, 1'b0, 16'h0010, 0, 0, -1);
      slow <= 1'b1;
      run(EAF_MODE_I, 4'h2, 2'h2, 2'h0, 1'b0, 1'b1, 1'b1, 16'h0008, 32'hA010_0038,
          32'hB010_1038, 0);
      slow <= 1'b0;
      run(EAF_MODE_I, 4'h2, 2'h3, 2'h0, 1'b0, 1'b1, 1'b1, 16'h0008, 32'hA010_0008,
          32'hB010_1038, 0);
      run(EAF_MODE_I, 4'h2, 2'h2, 2'h0, 1'b0, 1'b0, 1'b0, 16'h0020, 32'h0005_0020,
          32'h0005_1020, 0);
      run(EAF_MODE_R, 4'h1, 2'h0, 2'h3, 1'b0, 1'b0, 1'b0, 16'h0010, 0, 32'h0002_0010, 2);
      run(EAF_MODE_R, 4'h1, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 16'h0010, 0, 32'h0005_0010, 2);
      run(EAF_MODE_R, 4'h2, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0, 16'h0004, 0, 32'h0005_0404, 2);
      run(EAF_MODE_R, 4'h2, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 16'h0004, 0, 32'h0005_0004, 2);
      run(EAF_MODE_V, 4'h3, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 16'h0105, 0, 32'h0007_0005, 2);
      run(EAF_MODE_V, 4'h3, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0, 16'hFFFE, 0, 32'h0005_03FE, 2);
      run(EAF_MODE_S, 4'h2, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0, 16'h0002, 0, 32'h0005_0402, 2);
      ahb(1'b0, `EAF_EA_OFS, 32'h0, v);
      chk("ea_register", 32'h0005_0402, v);
      ahb(1'b0, `EAF_STAT_OFS, 32'h0, v);
      chk("status_idle", 32'h0, {31'h0, v[0]});
      report_and_stop();
   end
endmodule
`default_nettype wire
